// [dv/event_source.sv]
// event network stand-in that sends count ticks
`timescale 1ns/1ps
`default_nettype none
module event_source (
    // clock
    input wire logic clk_i,
    // event line
    output logic count_event_o
);
    // idle low, so a stale level never counts as a tick
    initial count_event_o = 1'b0;
    // n one-cycle ticks, gap+1 idle cycles after each (slow source)
    task automatic send(input int n, input int gap);
        repeat (n) begin
            @(posedge clk_i);
            count_event_o <= 1'b1;
            @(posedge clk_i);
            count_event_o <= 1'b0;
            repeat (gap) @(posedge clk_i);
        end
    endtask : send
endmodule : event_source
`default_nettype wire

// [dv/tb_base_timer_unit.sv]
// self-checking bench for the base timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    err_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_base_timer_unit;
    import timer_pkg::*;
    typedef struct {logic [2:0] sel; int div;} row_t;
    logic clk_i, rst_i, cyc, stb, we, ev, ovf, zp, mx, ack;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r, d, dummy;
    logic [2:0] mt;
    int err_count, compares, ovf_n, m1_n, zp_n, mx_n, t0;
    // prescale select beside the divide it should give
    row_t rows[8] = '{'{3'd0, 1}, '{3'd1, 2}, '{3'd2, 4}, '{3'd3, 8},
        '{3'd4, 16}, '{3'd5, 64}, '{3'd6, 256}, '{3'd7, 1024}};

    base_timer_unit #(.CHANNELS(3)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
        .count_event_i(ev), .overflow_event_o(ovf), .match_event_o(mt),
        .zero_point_o(zp), .max_o(mx));
    event_source ev_src (.clk_i(clk_i), .count_event_o(ev));

    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // pulse tallies of the overflow, channel one match, zero point and max outputs
    always @(posedge clk_i) begin
        if (ovf === 1'b1) ovf_n <= ovf_n + 1;
        if (mt[1] === 1'b1) m1_n <= m1_n + 1;
        if (zp === 1'b1) zp_n <= zp_n + 1;
        if (mx === 1'b1) mx_n <= mx_n + 1;
    end

    // one classic wishbone cycle, held until ack is sampled
    task automatic bus(input logic [5:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd_v);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= wd;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 64) begin
            @(posedge clk_i);
            n++;
        end
        rd_v = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 64) begin
            err_count++;
            $display("ERROR bus_ack expected 1 seen 0");
        end
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        bus(a, 1'b1, v, dummy);
    endtask : wr
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        bus(a, 1'b0, 32'h0, v);
    endtask : rd
    task automatic cr(input string nm, input logic [5:0] a,
                      input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(nm, e, v)
    endtask : cr
    // ticks from the partner, then let flags and events settle
    task automatic tick(input int n, input int gap);
        ev_src.send(n, gap);
        repeat (4) @(posedge clk_i);
    endtask : tick
    task automatic done_test(input string nm);
        $display("test %s done, %0d errors so far", nm, err_count);
    endtask : done_test
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 6'h00;
        sel = 4'hf;
        dat_w = 32'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, 16-bit storage, unmapped place
        cr("period", ADDR_PERIOD, 32'h0000ffff);
        cr("pshadow", ADDR_PERIOD_SHADOW, 32'h0000ffff);
        cr("count", ADDR_COUNT, 32'h0);
        cr("flags", ADDR_FLAGS, 32'h0);
        cr("unmapped", 6'h3c, 32'h0);
        wr(ADDR_COMPARE0, 32'hdeadbeef);
        cr("compare0", ADDR_COMPARE0, 32'h0000beef);
        wr(ADDR_SHADOW0, 32'h12345678);
        cr("shadow0", ADDR_SHADOW0, 32'h00005678);
        cr("valid_set0", ADDR_CONTROL_SIXTH, 32'h2);
        done_test("registers");
        // every prescale ratio: eight ticks' worth of enabled cycles
        foreach (rows[i]) begin
            wr(ADDR_COUNT, 32'h0);
            wr(ADDR_CONTROL_FIRST, {28'h0, rows[i].sel, 1'b1});
            repeat (8 * rows[i].div - 3) @(posedge clk_i);
            wr(ADDR_CONTROL_FIRST, 32'h0);
            rd(ADDR_COUNT, d);
            `CHK("ticks", 1'b1, d >= 7 && d <= 9)
        end
        repeat (2000) @(posedge clk_i);
        cr("count_held", ADDR_COUNT, 32'h8);
        cr("cmp_commit", ADDR_COMPARE0, 32'h00005678);
        cr("cmp_valid_clr", ADDR_CONTROL_SIXTH, 32'h0);
        done_test("prescaler");
        // event counting; no clock ticks while events are chosen
        wr(ADDR_EVENT_CONTROL, 32'h1);
        wr(ADDR_CONTROL_FIRST, 32'h1);
        cr("ev_ctl", ADDR_EVENT_CONTROL, 32'h1);
        cr("first_ctl", ADDR_CONTROL_FIRST, 32'h1);
        wr(ADDR_PERIOD, 32'h5);
        wr(ADDR_COUNT, 32'h3);
        repeat (50) @(posedge clk_i);
        cr("no_clk_ticks", ADDR_COUNT, 32'h3);
        t0 = ovf_n;
        tick(3, 0);
        cr("wrap_up", ADDR_COUNT, 32'h0);
        rd(ADDR_FLAGS, d);
        `CHK("ovf_flag", 1'b1, d[0])
        `CHK("ovf_events", t0 + 1, ovf_n)
        // down count through zero reloads the period, slow source
        wr(ADDR_COUNT, 32'h1);
        wr(ADDR_FLAGS, 32'hf);
        wr(ADDR_CONTROL_FIFTH, 32'h1);
        t0 = zp_n;
        tick(2, 3);
        cr("reload", ADDR_COUNT, 32'h5);
        `CHK("zero_seen", 1'b1, zp_n > t0)
        tick(2, 0);
        wr(ADDR_CONTROL_FIFTH, 32'h0);
        tick(1, 0);
        cr("dir_flip", ADDR_COUNT, 32'h4);
        done_test("events");
        // channel one compare at two
        wr(ADDR_COMPARE0 + 6'h04, 32'h2);
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_FLAGS, 32'hf);
        t0 = m1_n;
        tick(1, 0);
        rd(ADDR_FLAGS, d);
        `CHK("no_match", 1'b0, d[2])
        `CHK("match2_flag", 1'b1, d[3])
        tick(2, 0);
        rd(ADDR_FLAGS, d);
        `CHK("match_flag", 1'b1, d[2])
        `CHK("match_events", t0 + 1, m1_n)
        // buffered period waits for the top
        wr(ADDR_CONTROL_FIFTH, 32'h4);
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_PERIOD_SHADOW, 32'h3);
        cr("per_held", ADDR_PERIOD, 32'h5);
        cr("valid_set", ADDR_CONTROL_SIXTH, 32'h1);
        tick(6, 1);
        cr("per_commit", ADDR_PERIOD, 32'h3);
        cr("valid_clr", ADDR_CONTROL_SIXTH, 32'h0);
        // lock holds the shadow back until released
        wr(ADDR_CONTROL_FIFTH, 32'h6);
        cr("fifth_ctl", ADDR_CONTROL_FIFTH, 32'h6);
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_PERIOD_SHADOW, 32'h2);
        tick(5, 0);
        cr("locked", ADDR_PERIOD, 32'h3);
        cr("locked_valid", ADDR_CONTROL_SIXTH, 32'h1);
        wr(ADDR_CONTROL_FIFTH, 32'h4);
        tick(4, 0);
        cr("unlocked", ADDR_PERIOD, 32'h2);
        done_test("buffering");
        // unbuffered period below the count: run on, wrap, then new top
        wr(ADDR_CONTROL_FIFTH, 32'h0);
        wr(ADDR_PERIOD, 32'h10);
        wr(ADDR_COUNT, 32'hc);
        wr(ADDR_PERIOD, 32'h4);
        tick(2, 0);
        cr("runs_on", ADDR_COUNT, 32'he);
        wr(ADDR_COUNT, 32'hfffe);
        t0 = mx_n;
        tick(2, 0);
        cr("wrap_max", ADDR_COUNT, 32'h0);
        `CHK("max_seen", 1'b1, mx_n > t0)
        tick(5, 0);
        cr("new_top", ADDR_COUNT, 32'h0);
        // count write lands while the clock ticks every cycle
        wr(ADDR_EVENT_CONTROL, 32'h0);
        wr(ADDR_CONTROL_FIRST, 32'h1);
        wr(ADDR_COUNT, 32'h8000);
        wr(ADDR_CONTROL_FIRST, 32'h0);
        rd(ADDR_COUNT, d);
        `CHK("cnt_write", 1'b1, d >= 32'h8000 && d <= 32'h8004)
        done_test("period");
        // second reset in mid-run
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        cr("per_reset", ADDR_PERIOD, 32'h0000ffff);
        cr("cnt_reset", ADDR_COUNT, 32'h0);
        cr("flags_reset", ADDR_FLAGS, 32'h0);
        cr("first_reset", ADDR_CONTROL_FIRST, 32'h0);
        done_test("reset");
        tally_and_finish();
    end
    // cut a hang short; the tests need about 13500 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        $display("ERROR watchdog expected done seen running");
        tally_and_finish();
    end
endmodule : tb_base_timer_unit
`default_nettype wire

// [verilog/base_timer_unit.sv]
// buffered 16-bit up/down base timer with compare channels
// Notes on behaviour
// - count, period, compares, shadows all 16-bit
// - compare count to zero and period
// - compare count to each compare value
// - effects appear on the following tick
// - tick is prescaled clock or event
// - zero_point when count becomes zero
// - max is all ones; top is period
// - commit valid shadows at update unless locked
// - enable starts counting at prescaled rate
// - event enable counts events instead
// - count direction follows direction bit
// - up at top wraps to zero
// - down at zero_point reloads period
// - software count write wins, immediate
// - direction may change while running
// - valid flag set on write, cleared at update
// - compares and shadows both directly writable
// - unbuffered period write takes effect immediately
// - period below count means wrap first
// - buffered period changes only at update
// - compare match sets flag next tick
`timescale 1ns/1ps
`default_nettype none
module base_timer_unit #(
    parameter int CHANNELS = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // event network
    input wire logic count_event_i,
    output logic overflow_event_o,
    output logic [CHANNELS-1:0] match_event_o,
    // status
    output logic zero_point_o,
    output logic max_o
);
    import timer_pkg::*;

    // pulse-free next-tick helper: count step
    function automatic logic [15:0] step(input logic [15:0] v,
                                         input logic up);
        step = up ? v + 16'h0001 : v - 16'h0001;
    endfunction : step

    logic [15:0] count_reg, count_next;
    logic [15:0] period_reg, period_next;
    logic [15:0] period_shadow_reg, period_shadow_next;
    logic [15:0] compare_reg [CHANNELS];
    logic [15:0] compare_next [CHANNELS];
    logic [15:0] shadow_reg [CHANNELS];
    logic [15:0] shadow_next [CHANNELS];
    logic period_valid_reg, period_valid_next;
    logic [CHANNELS-1:0] cmp_valid_reg, cmp_valid_next;
    logic enable_reg, enable_next;
    logic [PRESCALE_W-1:0] prescale_select_reg, prescale_select_next;
    logic dir_down_reg, dir_down_next;
    logic lock_commit_reg, lock_commit_next;
    logic update_at_top_reg, update_at_top_next;
    logic event_count_enable_reg, event_count_enable_next;
    logic overflow_flag_reg, overflow_flag_next;
    logic [CHANNELS-1:0] match_flag_reg, match_flag_next;
    logic [PRESCALE_CNT_W-1:0] pre_cnt_reg, pre_cnt_next;
    logic [31:0] dat_reg, dat_next;
    logic ack_reg, ack_next;
    logic ovf_ev_reg, ovf_ev_next;
    logic [CHANNELS-1:0] match_ev_reg, match_ev_next;
    logic zero_reg, zero_next;
    logic max_reg, max_next;

    // bus access decode
    logic wr, rd_now;
    logic tick, at_top, at_zero_point, end_point, update_pt;
    logic [CHANNELS-1:0] match;
    logic [PRESCALE_CNT_W-1:0] pre_mask;
    logic wr_count, wr_period, wr_pshadow;
    logic [CHANNELS-1:0] wr_cmp, wr_shadow;

    // single-wait-state slave: ack one cycle after request
    assign wr = cyc_i & stb_i & we_i & ~ack_reg;
    assign rd_now = cyc_i & stb_i & ~ack_reg;
    assign wr_count = wr & (adr_i == ADDR_COUNT);
    assign wr_period = wr & (adr_i == ADDR_PERIOD);
    assign wr_pshadow = wr & (adr_i == ADDR_PERIOD_SHADOW);

    always_comb begin
        at_top = (count_reg == period_reg);
        at_zero_point = (count_reg == ZERO_POINT_VALUE);
        for (int i = 0; i < CHANNELS; i++) begin
            match[i] = (count_reg == compare_reg[i]);
            wr_cmp[i] = wr & (adr_i == ADDR_COMPARE0 + 6'(4 * i));
            wr_shadow[i] = wr & (adr_i == ADDR_SHADOW0 + 6'(4 * i));
        end
    end

    always_comb begin
        pre_mask = '0;
        case (prescale_select_reg)
            3'h0: pre_mask = 10'h000;
            3'h1: pre_mask = 10'h001;
            3'h2: pre_mask = 10'h003;
            3'h3: pre_mask = 10'h007;
            3'h4: pre_mask = 10'h00f;
            3'h5: pre_mask = 10'h03f;
            3'h6: pre_mask = 10'h0ff;
            3'h7: pre_mask = 10'h3ff;
            default: pre_mask = 10'h000;
        endcase
        pre_cnt_next = '0;
        if (enable_reg && !event_count_enable_reg)
            pre_cnt_next = (pre_cnt_reg & pre_mask) == pre_mask ? '0
                           : pre_cnt_reg + 10'h001;
    end

    // enable gates ticking; events replace clock
    always_comb begin
        if (!enable_reg)
            tick = 1'b0;
        else if (event_count_enable_reg)
            tick = count_event_i;
        else
            tick = ((pre_cnt_reg & pre_mask) == pre_mask);
    end

    // end of period in current direction, and commit point
    assign end_point = dir_down_reg ? at_zero_point : at_top;
    assign update_pt = tick & (update_at_top_reg ? at_top : at_zero_point);

    // counter and shadow state
    always_comb begin
        count_next = count_reg;
        period_next = period_reg;
        period_shadow_next = period_shadow_reg;
        period_valid_next = period_valid_reg;
        cmp_valid_next = cmp_valid_reg;
        for (int i = 0; i < CHANNELS; i++) begin
            compare_next[i] = compare_reg[i];
            shadow_next[i] = shadow_reg[i];
        end
        if (tick) begin
            // direction bit; read live each tick
            if (!dir_down_reg && at_top)
                count_next = ZERO_POINT_VALUE;
            else if (dir_down_reg && at_zero_point)
                count_next = period_reg;
            else
                // no top match above period: run on
                count_next = step(count_reg, !dir_down_reg);
        end
        if (update_pt && !lock_commit_reg) begin
            // period changes only here when buffered
            if (period_valid_reg)
                period_next = period_shadow_reg;
            period_valid_next = 1'b0;
            for (int i = 0; i < CHANNELS; i++)
                if (cmp_valid_reg[i])
                    compare_next[i] = shadow_reg[i];
            cmp_valid_next = '0;
        end
        if (wr_count)
            count_next = dat_i[15:0];
        if (wr_period)
            period_next = dat_i[15:0];
        // buffer write sets valid, over clear
        if (wr_pshadow) begin
            period_shadow_next = dat_i[15:0];
            period_valid_next = 1'b1;
        end
        for (int i = 0; i < CHANNELS; i++) begin
            if (wr_cmp[i])
                compare_next[i] = dat_i[15:0];
            if (wr_shadow[i]) begin
                shadow_next[i] = dat_i[15:0];
                cmp_valid_next[i] = 1'b1;
            end
        end
    end

    // control registers and flags
    always_comb begin
        enable_next = enable_reg;
        prescale_select_next = prescale_select_reg;
        dir_down_next = dir_down_reg;
        lock_commit_next = lock_commit_reg;
        update_at_top_next = update_at_top_reg;
        event_count_enable_next = event_count_enable_reg;
        overflow_flag_next = overflow_flag_reg;
        match_flag_next = match_flag_reg;
        if (wr && adr_i == ADDR_CONTROL_FIRST && sel_i[0]) begin
            enable_next = dat_i[ENABLE_BIT];
            prescale_select_next =
                dat_i[PRESCALE_LSB +: PRESCALE_W];
        end
        if (wr && adr_i == ADDR_CONTROL_FIFTH && sel_i[0]) begin
            dir_down_next = dat_i[DIR_BIT];
            lock_commit_next = dat_i[LOCK_BIT];
            update_at_top_next = dat_i[UPDATE_AT_TOP_BIT];
        end
        if (wr && adr_i == ADDR_EVENT_CONTROL && sel_i[0])
            event_count_enable_next = dat_i[0];
        // write one to clear flags
        if (wr && adr_i == ADDR_FLAGS && sel_i[0]) begin
            overflow_flag_next = overflow_flag_reg
                                 & ~dat_i[OVERFLOW_FLAG_BIT];
            match_flag_next = match_flag_reg & ~dat_i[CHANNELS:1];
        end
        // overflow flag on end point; set beats clear
        if (tick && end_point)
            overflow_flag_next = 1'b1;
        // compare flag set on the tick after match
        // taken at the tick edge following condition
        match_flag_next = match_flag_next
                          | (match & {CHANNELS{tick}});
        // event pulses on that same tick
        ovf_ev_next = tick & end_point;
        match_ev_next = match & {CHANNELS{tick}};
        zero_next = at_zero_point;
        max_next = (count_reg == MAX_VALUE);
    end

    // read mux and acknowledge
    always_comb begin
        dat_next = 32'h0000_0000;
        ack_next = rd_now;
        if (rd_now && !we_i) begin
            case (adr_i)
                ADDR_CONTROL_FIRST: dat_next = 32'(
                    {prescale_select_reg, enable_reg});
                ADDR_CONTROL_FIFTH: dat_next = 32'(
                    {update_at_top_reg, lock_commit_reg, dir_down_reg});
                ADDR_CONTROL_SIXTH: dat_next = 32'(
                    {cmp_valid_reg, period_valid_reg});
                ADDR_EVENT_CONTROL: dat_next = 32'(event_count_enable_reg);
                ADDR_FLAGS: dat_next = 32'(
                    {match_flag_reg, overflow_flag_reg});
                ADDR_COUNT: dat_next = 32'(count_reg);
                ADDR_PERIOD: dat_next = 32'(period_reg);
                ADDR_PERIOD_SHADOW: dat_next = 32'(period_shadow_reg);
                default: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (adr_i == ADDR_COMPARE0 + 6'(4 * i))
                            dat_next = 32'(compare_reg[i]);
                        if (adr_i == ADDR_SHADOW0 + 6'(4 * i))
                            dat_next = 32'(shadow_reg[i]);
                    end
                end
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= COUNT_RESET;
            period_reg <= PERIOD_RESET;
            period_shadow_reg <= PERIOD_RESET;
            period_valid_reg <= 1'b0;
            cmp_valid_reg <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                compare_reg[i] <= COUNT_RESET;
                shadow_reg[i] <= COUNT_RESET;
            end
            enable_reg <= 1'b0;
            prescale_select_reg <= '0;
            dir_down_reg <= 1'b0;
            lock_commit_reg <= 1'b0;
            update_at_top_reg <= 1'b0;
            event_count_enable_reg <= 1'b0;
            overflow_flag_reg <= 1'b0;
            match_flag_reg <= '0;
            pre_cnt_reg <= '0;
            dat_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            ovf_ev_reg <= 1'b0;
            match_ev_reg <= '0;
            zero_reg <= 1'b0;
            max_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            period_reg <= period_next;
            period_shadow_reg <= period_shadow_next;
            period_valid_reg <= period_valid_next;
            cmp_valid_reg <= cmp_valid_next;
            for (int i = 0; i < CHANNELS; i++) begin
                compare_reg[i] <= compare_next[i];
                shadow_reg[i] <= shadow_next[i];
            end
            enable_reg <= enable_next;
            prescale_select_reg <= prescale_select_next;
            dir_down_reg <= dir_down_next;
            lock_commit_reg <= lock_commit_next;
            update_at_top_reg <= update_at_top_next;
            event_count_enable_reg <= event_count_enable_next;
            overflow_flag_reg <= overflow_flag_next;
            match_flag_reg <= match_flag_next;
            pre_cnt_reg <= pre_cnt_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
            ovf_ev_reg <= ovf_ev_next;
            match_ev_reg <= match_ev_next;
            zero_reg <= zero_next;
            max_reg <= max_next;
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign overflow_event_o = ovf_ev_reg;
    assign match_event_o = match_ev_reg;
    assign zero_point_o = zero_reg;
    assign max_o = max_reg;

    // checks
    property p_wrap_up;
        @(posedge clk_i) disable iff (rst_i)
        tick && !dir_down_reg && at_top && !wr_count
            |=> count_reg == ZERO_POINT_VALUE;
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("no wrap");
    property p_reload;
        @(posedge clk_i) disable iff (rst_i)
        tick && dir_down_reg && at_zero_point && !wr_count
            |=> count_reg == $past(period_reg);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");
    property p_count_wr;
        @(posedge clk_i) disable iff (rst_i)
        wr_count |=> count_reg == $past(dat_i[15:0]);
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("count");
    property p_idle;
        @(posedge clk_i) disable iff (rst_i)
        !enable_reg && !wr_count |=> $stable(count_reg);
    endproperty
    a_idle: assert property (p_idle) else $error("ran while off");
    property p_ovf_ev;
        @(posedge clk_i) disable iff (rst_i)
        tick && end_point |=> overflow_event_o && overflow_flag_reg;
    endproperty
    a_ovf_ev: assert property (p_ovf_ev) else $error("no ovf");
    // any channel: flag and event follow the matching tick
    property p_match;
        @(posedge clk_i) disable iff (rst_i)
        tick && (match != '0) |=> match_event_o == $past(match)
            && (match_flag_reg & $past(match)) == $past(match);
    endproperty
    a_match: assert property (p_match) else $error("no match");
    // a commit with no period or shadow write in that cycle loads the shadow and clears valid
    property p_commit;
        @(posedge clk_i) disable iff (rst_i)
        update_pt && !lock_commit_reg && period_valid_reg
            && !wr_period && !wr_pshadow
            |=> period_reg == $past(period_shadow_reg)
                && !period_valid_reg;
    endproperty
    a_commit: assert property (p_commit) else $error("no commit");
    property p_locked;
        @(posedge clk_i) disable iff (rst_i)
        lock_commit_reg && !wr_period |=> $stable(period_reg);
    endproperty
    a_locked: assert property (p_locked) else $error("locked");
    property p_valid_set;
        @(posedge clk_i) disable iff (rst_i)
        wr_pshadow |=> period_valid_reg;
    endproperty
    a_valid_set: assert property (p_valid_set) else $error("bv");
    c_wrap: cover property (@(posedge clk_i) tick && at_top);
    c_reload: cover property (@(posedge clk_i) tick && dir_down_reg
                              && at_zero_point);
    c_commit: cover property (@(posedge clk_i) update_pt
                              && period_valid_reg);
endmodule : base_timer_unit
`default_nettype wire

// [verilog/timer_pkg.sv]
// constants for the buffered up/down base timer
package timer_pkg;
    // register word byte addresses (wishbone, 32-bit data)
    localparam logic [5:0] ADDR_CONTROL_FIRST = 6'h00;
    localparam logic [5:0] ADDR_CONTROL_FIFTH = 6'h04;
    localparam logic [5:0] ADDR_CONTROL_SIXTH = 6'h08;
    localparam logic [5:0] ADDR_EVENT_CONTROL = 6'h0c;
    localparam logic [5:0] ADDR_FLAGS = 6'h10;
    localparam logic [5:0] ADDR_COUNT = 6'h14;
    localparam logic [5:0] ADDR_PERIOD = 6'h18;
    localparam logic [5:0] ADDR_PERIOD_SHADOW = 6'h1c;
    localparam logic [5:0] ADDR_COMPARE0 = 6'h20;
    localparam logic [5:0] ADDR_SHADOW0 = 6'h30;
    // control_first fields
    localparam int ENABLE_BIT = 0;
    localparam int PRESCALE_LSB = 1;
    localparam int PRESCALE_W = 3;
    // control_fifth fields
    localparam int DIR_BIT = 0;
    localparam int LOCK_BIT = 1;
    localparam int UPDATE_AT_TOP_BIT = 2;
    // control_sixth: bit 0 period valid, bits 1..n compare valid
    localparam int PERIOD_VALID_BIT = 0;
    // flags: bit 0 overflow, bits 1..n compare match
    localparam int OVERFLOW_FLAG_BIT = 0;
    // reset values, zero point and max count values
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] ZERO_POINT_VALUE = 16'h0000;
    localparam logic [15:0] MAX_VALUE = 16'hffff;
    // prescaler divider width (largest ratio 2**10)
    localparam int PRESCALE_CNT_W = 10;
endpackage : timer_pkg
